// File: cmd_arbiter_map.svh
// Register offsets, field positions, reset values and timing counts of the command arbiter.
`ifndef CMD_ARBITER_MAP_SVH
`define CMD_ARBITER_MAP_SVH
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_IRQ_STAT 12'h008
`define REG_IRQ_MASK 12'h00C
`define REG_ANALOG 12'h010
`define REG_CURRENT 12'h014
`define REG_DCEQ 12'h018
// Control word fields.
`define CTRL_PRIO2_LSB 0
`define CTRL_PRIO3_LSB 2
`define CTRL_ENC_EN 4
`define CTRL_P1_EN 5
`define CTRL_P2_EN 6
`define CTRL_SAFE_EN 7
`define CTRL_OPEN_DRAIN_OUTPUT_ONE 8
`define CTRL_BRAKE 9
`define CTRL_FAULT 10
`define CTRL_SINUS 11
`define CTRL_CAN_EN 12
`define CTRL_RESET 32'h0000_00EA
// Analog limits in millivolts and the centre window; 4750 mV needs thirteen bits.
`define ANA_LOW_MV 13'd250
`define ANA_HIGH_MV 13'd4750
`define ANA_CENTRE_MV 13'd2500
`define ANA_CENTRE_TOL_MV 13'd100
// Scale factors in Q2.14: 1.414 and 1.225.
`define K_SINUS 16'h5A7F
`define K_TRAP 16'h4E66
// Status LED period and clock.
`define CLK_HZ 200000000
`define LED_PERIOD_MS 2000
`endif

// File: cmd_arbiter_pkg.sv
// Types shared by the command arbiter.
`default_nettype none
package cmd_arbiter_pkg;
    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_SERIAL = 2'b01,
        SRC_PULSE = 2'b10,
        SRC_ANALOG = 2'b11
    } src_e;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic [12:0] analog_mv;
        logic [15:0] current;
        logic [15:0] dceq;
        src_e active;
        logic inhibit;
        logic [31:0] prdata;
        logic [27:0] led_cnt;
        logic [3:0] led_phase;
        logic [1:0] s_sync1;
        logic [1:0] s_sync2;
    } state_s;
endpackage
`default_nettype wire

// File: command_arbiter_status_indicators.sv
// Command source arbiter with analog safety, shared pin control, outputs and LEDs.
//
// Notes on behaviour
// - Pick serial first, then the sources in priority slots two and three, else no command source.
// - Analog off at reset; enabled only in priority slot two or three.
// - Safety checks inhibit start unless centred and within 0.25V to 4.75V.
// - Power LED on; status LED flashes at two second period, pattern by fault.
// - Comm LED: off, on, mostly on, mostly off by USB and CAN.
// - Encoder off by default; usable only with both pulse inputs off.
// - Digital outputs are open drain: pull low when on, float when off.
// - Brake output driven identically on both connector pins.
// - Drive differential SSI clock; encoder returns differential data.
// - DC equivalent is RMS current times 1.414 sinusoidal or 1.225 trapezoidal.
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "cmd_arbiter_map.svh"
module command_arbiter_status_indicators
    import cmd_arbiter_pkg::*;
#(
    parameter int unsigned LED_PERIOD_CYC = (`CLK_HZ / 1000) * `LED_PERIOD_MS
) (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // APB slave.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic irq_out,
    // Command validity from the decoders.
    input wire logic serial_valid_in,
    input wire logic pulse_valid_in,
    input wire logic analog_valid_in,
    // Link state pins.
    input wire logic usb_active_in,
    input wire logic can_active_in,
    // Selected source and gating.
    output logic [1:0] active_source_out,
    output logic start_inhibit_out,
    output logic encoder_enable_out,
    output logic pulse_input_one_enable_out,
    output logic pulse_input_two_enable_out,
    // Open-drain outputs, low when driven.
    output logic open_drain_output_one_out,
    output logic open_drain_output_one_oe_out,
    output logic brake_release_output_out,
    output logic brake_release_output_oe_out,
    output logic brake_sensor_pin_out,
    output logic brake_sensor_pin_oe_out,
    // SSI encoder pins.
    input wire logic ssi_clk_in,
    input wire logic ssi_data_p_in,
    input wire logic ssi_data_n_in,
    output logic ssi_clk_p_out,
    output logic ssi_clk_n_out,
    output logic ssi_data_out,
    // Indicators.
    output logic power_led_out,
    output logic status_led_green_out,
    output logic status_led_red_out,
    output logic comm_led_out
);
    localparam int unsigned SLOT_CYC = LED_PERIOD_CYC / 16;

    state_s q, d;

    function automatic logic [15:0] scale(input logic [15:0] i, input logic [15:0] k);
        logic [31:0] p;
        p = i * k;
        return p[29:14];
    endfunction

    function automatic logic is_analog(input logic [1:0] slot);
        return slot == SRC_ANALOG;
    endfunction

    logic wr, rd, ana_ok, ana_en, enc_ok;
    logic [1:0] slot2, slot3;
    logic [3:0] events;
    logic [31:0] ctrl_w;

    always_comb begin
        d = q;
        ctrl_w = q.ctrl;
        wr = psel_in && penable_in && pwrite_in;
        rd = psel_in && !penable_in && !pwrite_in;
        slot2 = q.ctrl[`CTRL_PRIO2_LSB +: 2];
        slot3 = q.ctrl[`CTRL_PRIO3_LSB +: 2];
        // Slot one is always serial; analog may only sit in slot two or three.
        ana_en = is_analog(slot2) || is_analog(slot3);
        // Safety window checked against the latest sampled voltage.
        ana_ok = !q.ctrl[`CTRL_SAFE_EN] ||
            (q.analog_mv >= `ANA_LOW_MV && q.analog_mv <= `ANA_HIGH_MV &&
             q.analog_mv >= `ANA_CENTRE_MV - `ANA_CENTRE_TOL_MV &&
             q.analog_mv <= `ANA_CENTRE_MV + `ANA_CENTRE_TOL_MV);
        // Arbitration runs every cycle so a lost source falls back at once.
        d.active = SRC_NONE;
        if (serial_valid_in) begin
            d.active = SRC_SERIAL;
        end else if (slot2 == SRC_PULSE && pulse_valid_in) begin
            d.active = SRC_PULSE;
        end else if (is_analog(slot2) && analog_valid_in) begin
            d.active = SRC_ANALOG;
        end else if (slot3 == SRC_PULSE && pulse_valid_in) begin
            d.active = SRC_PULSE;
        end else if (is_analog(slot3) && analog_valid_in) begin
            d.active = SRC_ANALOG;
        end
        d.inhibit = ana_en && d.active == SRC_ANALOG && !ana_ok;
        d.dceq = q.ctrl[`CTRL_SINUS] ? scale(q.current, `K_SINUS)
                                    : scale(q.current, `K_TRAP);
        d.s_sync1 = {usb_active_in, can_active_in};
        d.s_sync2 = q.s_sync1;
        // Events: source change, inhibit rise, fault, encoder request refused.
        enc_ok = q.ctrl[`CTRL_ENC_EN] && !q.ctrl[`CTRL_P1_EN] && !q.ctrl[`CTRL_P2_EN];
        events = {q.ctrl[`CTRL_ENC_EN] && !enc_ok, q.ctrl[`CTRL_FAULT],
                  d.inhibit && !q.inhibit, d.active != q.active};
        // Write one clears, but a new event in the same cycle wins.
        if (wr && paddr_in == `REG_IRQ_STAT) begin
            d.irq_stat = q.irq_stat & ~pwdata_in[3:0];
        end
        d.irq_stat = d.irq_stat | events;
        if (wr) begin
            unique case (paddr_in)
                `REG_CTRL: begin
                    ctrl_w = pwdata_in;
                    // Serial in slot two is forced back to pulse; serial in slot three is cleared to none.
                    if (ctrl_w[`CTRL_PRIO2_LSB +: 2] == SRC_SERIAL) begin
                        ctrl_w[`CTRL_PRIO2_LSB +: 2] = SRC_PULSE;
                    end
                    if (ctrl_w[`CTRL_PRIO3_LSB +: 2] == SRC_SERIAL) begin
                        ctrl_w[`CTRL_PRIO3_LSB +: 2] = SRC_NONE;
                    end
                    d.ctrl = ctrl_w;
                end
                `REG_IRQ_MASK: d.irq_mask = pwdata_in[3:0];
                `REG_ANALOG: d.analog_mv = pwdata_in[12:0];
                `REG_CURRENT: d.current = pwdata_in[15:0];
                default: ctrl_w = q.ctrl;
            endcase
        end else begin
            ctrl_w = q.ctrl;
        end
        if (rd) begin
            unique case (paddr_in)
                `REG_CTRL: d.prdata = q.ctrl;
                `REG_STATUS: d.prdata = {26'h000_0000, q.s_sync2, q.inhibit, enc_ok, q.active};
                `REG_IRQ_STAT: d.prdata = {28'h000_0000, q.irq_stat};
                `REG_IRQ_MASK: d.prdata = {28'h000_0000, q.irq_mask};
                `REG_ANALOG: d.prdata = {19'h0_0000, q.analog_mv};
                `REG_CURRENT: d.prdata = {16'h0000, q.current};
                `REG_DCEQ: d.prdata = {16'h0000, q.dceq};
                default: d.prdata = 32'h0000_0000;
            endcase
        end
        // Two second frame split into sixteen slots for the flash patterns.
        if (q.led_cnt >= 28'(SLOT_CYC - 1)) begin
            d.led_cnt = 28'h000_0000;
            d.led_phase = q.led_phase + 4'h1;
        end else begin
            d.led_cnt = q.led_cnt + 28'h000_0001;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '0;
            q.ctrl <= `CTRL_RESET;
            q.active <= SRC_NONE;
        end else begin
            q <= d;
        end
    end

    // Any unmapped address still completes, returning zero with no error.
    assign prdata_out = q.prdata;
    assign pready_out = 1'b1;
    assign pslverr_out = 1'b0;
    assign irq_out = |(q.irq_stat & q.irq_mask);

    assign active_source_out = q.active;
    assign start_inhibit_out = q.inhibit;
    // Shared pins: the encoder wins only when both pulse inputs are off.
    assign encoder_enable_out = enc_ok;
    assign pulse_input_one_enable_out = q.ctrl[`CTRL_P1_EN];
    assign pulse_input_two_enable_out = q.ctrl[`CTRL_P2_EN];

    // Pins are only ever pulled low; the load returns them high.
    assign open_drain_output_one_out = 1'b0;
    assign open_drain_output_one_oe_out = q.ctrl[`CTRL_OPEN_DRAIN_OUTPUT_ONE];
    assign brake_release_output_out = 1'b0;
    assign brake_release_output_oe_out = q.ctrl[`CTRL_BRAKE];
    assign brake_sensor_pin_out = 1'b0;
    assign brake_sensor_pin_oe_out = q.ctrl[`CTRL_BRAKE];

    // The SSI clock is generated elsewhere; this block only drives the pair.
    assign ssi_clk_p_out = ssi_clk_in;
    assign ssi_clk_n_out = !ssi_clk_in;
    assign ssi_data_out = ssi_data_p_in && !ssi_data_n_in;

    assign power_led_out = 1'b1;
    // Normal is a short green blip; fault is a long red flash.
    assign status_led_green_out = !q.ctrl[`CTRL_FAULT] && q.led_phase == 4'h0;
    assign status_led_red_out = q.ctrl[`CTRL_FAULT] && q.led_phase < 4'h8;
    // Comm LED takes the synchronised link flags.
    assign comm_led_out = q.s_sync2 == 2'b10 ? 1'b1 :
                          q.s_sync2 == 2'b01 ? q.led_phase[3:2] != 2'b11 :
                          q.s_sync2 == 2'b11 ? q.led_phase[3:2] == 2'b11 : 1'b0;
endmodule
`default_nettype wire

// File: cmd_arbiter_checker.sv
// Port-level assertions for the command arbiter.
`timescale 1ns/1ps
`default_nettype none
module cmd_arbiter_checker (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Command validity and selection.
    input wire logic serial_valid_in,
    input wire logic pulse_valid_in,
    input wire logic analog_valid_in,
    input wire logic [1:0] active_source_out,
    input wire logic start_inhibit_out,
    input wire logic encoder_enable_out,
    input wire logic pulse_input_one_enable_out,
    input wire logic pulse_input_two_enable_out,
    // Outputs and indicators.
    input wire logic open_drain_output_one_out,
    input wire logic brake_release_output_out,
    input wire logic brake_sensor_pin_out,
    input wire logic brake_release_output_oe_out,
    input wire logic brake_sensor_pin_oe_out,
    input wire logic power_led_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_serial_first: assert property (serial_valid_in |=> active_source_out == 2'h1)
        else $error("serial command not selected");
    a_idle_none: assert property (!serial_valid_in && !pulse_valid_in && !analog_valid_in
        |=> active_source_out == 2'h0) else $error("source kept without valid command");
    a_pulse_cause: assert property (active_source_out == 2'h2
        |-> $past(pulse_valid_in) && !$past(serial_valid_in)) else $error("pulse chosen wrongly");
    a_analog_cause: assert property (active_source_out == 2'h3
        |-> $past(analog_valid_in) && !$past(serial_valid_in)) else $error("analog chosen wrongly");
    a_open_drain: assert property (!open_drain_output_one_out && !brake_release_output_out
        && !brake_sensor_pin_out) else $error("open drain pin driven high");
    a_brake_mirror: assert property (brake_release_output_oe_out == brake_sensor_pin_oe_out)
        else $error("brake pins differ");
    a_enc_exclusive: assert property (encoder_enable_out
        |-> !pulse_input_one_enable_out && !pulse_input_two_enable_out) else $error("pins shared");
    a_power_on: assert property (power_led_out)
        else $error("power indicator off");
    a_inhibit_analog: assert property (start_inhibit_out
        |-> active_source_out == 2'h3) else $error("start inhibited without analog source");
endmodule
`default_nettype wire

// File: cmd_source_model.sv
// Far-side sources: command decoders and an SSI encoder data pair.
`timescale 1ns/1ps
`default_nettype none
module cmd_source_model (
    // Clock and requested validity.
    input wire logic core_clk_in,
    input wire logic [2:0] want_in,
    // Validity levels and encoder data.
    output logic [2:0] valid_out,
    output logic ssi_data_p_out,
    output logic ssi_data_n_out
);
    logic bit_q = 1'b0;
    // Validity lags a request by a cycle, as a real decoder needs time to judge a frame.
    always @(posedge core_clk_in) begin
        valid_out <= want_in;
        bit_q <= ~bit_q;
    end
    assign ssi_data_p_out = bit_q;
    assign ssi_data_n_out = ~bit_q;
endmodule
`default_nettype wire

// File: command_arbiter_status_indicators_tb_top.sv
// Self-checking bench for the command arbiter.
`timescale 1ns/1ps
`default_nettype none
`include "cmd_arbiter_map.svh"
module command_arbiter_status_indicators_tb_top;
    logic core_clk_in = 1'b0, rst_n_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0;
    logic pwrite_in = 1'b0, usb_active_in = 1'b0, can_active_in = 1'b0, ssi_clk_in = 1'b0;
    logic [11:0] paddr_in = 12'h0;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
    logic [2:0] want = 3'h0, vld;
    logic [1:0] active_source_out;
    logic pready_out, pslverr_out, irq_out, start_inhibit_out, encoder_enable_out, ssi_data_out;
    logic pulse_input_one_enable_out, pulse_input_two_enable_out, open_drain_output_one_out;
    logic open_drain_output_one_oe_out, brake_release_output_out, brake_release_output_oe_out;
    logic brake_sensor_pin_out, brake_sensor_pin_oe_out, ssi_data_p_in, ssi_data_n_in;
    logic ssi_clk_p_out, ssi_clk_n_out, power_led_out, comm_led_out, led_g, led_r;
    int err_total = 0;
    int check_count = 0;
    int n_comm, n_grn, n_red;
    localparam int unsigned LED_CYC = 160;
    always #2.5 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) ssi_clk_in <= ~ssi_clk_in;
    // A short LED period keeps the run brief; only the scale of the flash changes.
    command_arbiter_status_indicators #(.LED_PERIOD_CYC(LED_CYC)) uut (.core_clk_in, .rst_n_in,
        .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
        .pslverr_out, .irq_out, .serial_valid_in(vld[0]), .pulse_valid_in(vld[1]),
        .analog_valid_in(vld[2]), .usb_active_in, .can_active_in, .active_source_out,
        .start_inhibit_out, .encoder_enable_out, .pulse_input_one_enable_out,
        .pulse_input_two_enable_out, .open_drain_output_one_out, .open_drain_output_one_oe_out,
        .brake_release_output_out, .brake_release_output_oe_out, .brake_sensor_pin_out,
        .brake_sensor_pin_oe_out, .ssi_clk_in, .ssi_data_p_in, .ssi_data_n_in, .ssi_clk_p_out,
        .ssi_clk_n_out, .ssi_data_out, .power_led_out, .status_led_green_out(led_g),
        .status_led_red_out(led_r), .comm_led_out);
    cmd_source_model far (.core_clk_in, .want_in(want), .valid_out(vld),
        .ssi_data_p_out(ssi_data_p_in), .ssi_data_n_out(ssi_data_n_in));
    task automatic final_report();
        if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        int n;
        @(posedge core_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= addr;
        pwdata_in <= data;
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 50);
        rd = prdata_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        if (pready_out !== 1'b1) begin
            err_total++;
            final_report();
        end
    endtask
    // Counts lit cycles over exactly one LED period, so the phase at entry does not matter.
    task automatic count_leds();
        n_comm = 0;
        n_grn = 0;
        n_red = 0;
        repeat (LED_CYC) begin
            @(negedge core_clk_in);
            n_comm += comm_led_out;
            n_grn += led_g;
            n_red += led_r;
        end
    endtask
    task automatic drive(input logic [2:0] w, input logic usb, input logic can);
        @(posedge core_clk_in);
        want <= w;
        usb_active_in <= usb;
        can_active_in <= can;
        repeat (6) @(posedge core_clk_in);
        @(negedge core_clk_in);
    endtask
    initial begin
        repeat (5) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        apb(1'b0, `REG_CTRL, 32'h0);
        chk("ctrl_reset", rd, `CTRL_RESET);
        chk("power_led", power_led_out, 32'h1);
        apb(1'b1, `REG_IRQ_MASK, 32'h1);
        drive(3'h3, 1'b1, 1'b0);
        chk("src_serial", active_source_out, 32'h1);
        chk("comm_usb", comm_led_out, 32'h1);
        chk("irq_raise", irq_out, 32'h1);
        apb(1'b1, `REG_IRQ_STAT, 32'hF);
        @(negedge core_clk_in);
        chk("irq_clear", irq_out, 32'h0);
        drive(3'h2, 1'b0, 1'b0);
        chk("src_fallback", active_source_out, 32'h2);
        chk("comm_off", comm_led_out, 32'h0);
        drive(3'h0, 1'b0, 1'b0);
        chk("src_none", active_source_out, 32'h0);
        chk("irq_again", irq_out, 32'h1);
        apb(1'b1, `REG_IRQ_MASK, 32'h0);
        @(negedge core_clk_in);
        chk("irq_masked", irq_out, 32'h0);
        apb(1'b1, `REG_CURRENT, 32'h64);
        apb(1'b0, `REG_DCEQ, 32'h0);
        chk("dceq_trap", rd, 32'h7A);
        apb(1'b1, `REG_CTRL, 32'h0000_0BE5);
        apb(1'b0, `REG_DCEQ, 32'h0);
        chk("dceq_sin", rd, 32'h8D);
        chk("open_drain_output_one_sink", open_drain_output_one_oe_out, 32'h1);
        chk("brake_sink", brake_sensor_pin_oe_out, 32'h1);
        chk("brake_main", brake_release_output_oe_out, 32'h1);
        chk("no_slverr", pslverr_out, 32'h0);
        apb(1'b1, `REG_CTRL, 32'h95);
        @(negedge core_clk_in);
        apb(1'b0, 12'h0FC, 32'h0);
        chk("unmapped", rd, 32'h0);
        chk("enc_on", encoder_enable_out, 32'h1);
        chk("open_drain_output_one_float", open_drain_output_one_oe_out, 32'h0);
        apb(1'b1, `REG_CTRL, 32'hB5);
        @(negedge core_clk_in);
        chk("enc_refused", encoder_enable_out, 32'h0);
        apb(1'b1, `REG_CTRL, 32'hE7);
        @(negedge core_clk_in);
        chk("enc_blocked", encoder_enable_out, 32'h0);
        apb(1'b1, `REG_ANALOG, 32'h64);
        drive(3'h4, 1'b0, 1'b1);
        chk("src_analog", active_source_out, 32'h3);
        chk("inhibit_low", start_inhibit_out, 32'h1);
        apb(1'b1, `REG_ANALOG, 32'h9C4);
        drive(3'h4, 1'b0, 1'b1);
        chk("inhibit_centre", start_inhibit_out, 32'h0);
        chk("ssi_data", ssi_data_out, {31'h0, ssi_data_p_in});
        chk("ssi_clk_pair", ssi_clk_p_out ^ ssi_clk_n_out, 32'h1);
        count_leds();
        chk("comm_can", n_comm, LED_CYC * 3 / 4);
        chk("status_green", n_grn != 0, 32'h1);
        chk("status_red_off", n_red, 32'h0);
        drive(3'h4, 1'b1, 1'b1);
        count_leds();
        chk("comm_both", n_comm, LED_CYC / 4);
        apb(1'b1, `REG_CTRL, 32'h0000_04EA);
        count_leds();
        chk("fault_red", n_red != 0, 32'h1);
        chk("fault_green_off", n_grn, 32'h0);
        final_report();
    end
endmodule
bind command_arbiter_status_indicators cmd_arbiter_checker chk_i (.core_clk_in, .rst_n_in,
    .serial_valid_in, .pulse_valid_in, .analog_valid_in, .active_source_out, .start_inhibit_out,
    .encoder_enable_out,
    .pulse_input_one_enable_out, .pulse_input_two_enable_out, .open_drain_output_one_out,
    .brake_release_output_out, .brake_sensor_pin_out, .brake_release_output_oe_out,
    .brake_sensor_pin_oe_out, .power_led_out);
`default_nettype wire
